/* hw/sra_core.sv */
// Sensor index relay, shutter relay, Z source and recorder output assignment.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module sra_core
#(
	parameter int NSRC       = 2,
	parameter int SEC_CYCLES = sra_pkg::SEC_CYCLES
)
(
	// Clock and reset.
	input  wire logic                    clk,
	input  wire logic                    nrst,
	// Register port.
	input  wire logic [7:0]              addr,
	input  wire logic [31:0]             wdata,
	input  wire logic                    wrEn,
	input  wire logic                    rdEn,
	output logic      [31:0]             rdata,
	// Layer and process events.
	input  wire logic                    switchReq,
	input  wire logic [2:0]              layerState,
	input  wire logic                    rateSample,
	input  wire logic                    rateHold,
	input  wire logic                    stopCmd,
	input  wire logic                    layerStart,
	input  wire logic [$clog2(NSRC)-1:0] layerSrc,
	// Auto Z calculation.
	input  wire logic                    zUnqualified,
	input  wire logic [15:0]             zCalcValue,
	input  wire logic                    zCalcFail,
	input  wire logic                    crystalReplaced,
	// Recorder contenders on this sensor's analog output.
	input  wire logic                    materialActive,
	input  wire logic                    recWanted,
	input  wire logic                    snsPrimary,
	input  wire logic                    priAggOn,
	input  wire logic                    secAggOn,
	input  wire logic                    otherSnsOn,
	input  wire logic                    otherSnsPrimary,
	// Outputs.
	output logic      [37:0]             relayOut,
	output logic      [3:0]              recDac,
	output logic      [3:0]              recFunc,
	output logic                         recActive,
	output logic      [1:0]              recOwner,
	output logic                         recConflict,
	output logic                         stopReq
);

	typedef enum {SQ_IDLE, SQ_ON1, SQ_OFF1, SQ_ON2} sra_seq_t;

	function automatic logic f_multi(input logic [2:0] t);
		f_multi = (t == sra_pkg::HT_DUAL) || (t == sra_pkg::HT_SIX) || (t == sra_pkg::HT_ROTARY);
	endfunction : f_multi

	function automatic logic f_hit(input logic [5:0] sel, input int i);
		f_hit = (sel != 6'h00) && (sel == 6'(i + 1));
	endfunction : f_hit

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers and write checks.

	logic [2:0]            headType;
	logic [5:0]            idxSel;
	logic [5:0]            shutSel;
	logic                  shutNc;
	logic                  zSel;
	logic [NSRC-1:0][3:0]  srcDac;
	logic [2:0]            errCode;
	logic                  rejSticky;
	logic                  noSrcSticky;
	logic [2:0]            next_headType;
	logic [5:0]            next_idxSel;
	logic [5:0]            next_shutSel;
	logic                  next_shutNc;
	logic                  next_zSel;
	logic [NSRC-1:0][3:0]  next_srcDac;
	logic [2:0]            next_errCode;
	logic                  next_rejSticky;
	logic                  next_noSrcSticky;
	logic [3:0]            next_recDac;
	logic [3:0]            next_recFunc;
	logic                  headAccepted;
	logic                  busy;
	logic                  noSrc;

	always_comb
	begin
		logic [2:0] rej;
		rej = sra_pkg::ER_NONE;
		headAccepted = 1'b0;
		next_headType = headType;
		next_idxSel = idxSel;
		next_shutSel = shutSel;
		next_shutNc = shutNc;
		next_zSel = zSel;
		next_srcDac = srcDac;
		next_recDac = recDac;
		next_recFunc = recFunc;
		next_errCode = errCode;
		next_rejSticky = rejSticky;
		next_noSrcSticky = noSrcSticky;
		if (wrEn)
		begin
			case (addr)
				sra_pkg::A_HEAD:
				begin
					if (!(f_multi(wdata[2:0]) || wdata[2:0] == sra_pkg::HT_SINGLE))
						rej = sra_pkg::ER_RANGE;
					else if (f_multi(wdata[2:0]) && idxSel == 6'h00)
						rej = sra_pkg::ER_IDXREQ;
					else if (busy)
						rej = sra_pkg::ER_BUSY;
					else
					begin
						next_headType = wdata[2:0];
						headAccepted = 1'b1;
					end
				end
				sra_pkg::A_IDX:
				begin
					if (wdata[7:0] > 8'(sra_pkg::RELAY_MAX))
						rej = sra_pkg::ER_RANGE;
					else if (wdata[5:0] == 6'h00 && f_multi(headType))
						rej = sra_pkg::ER_IDXREQ;
					else
						next_idxSel = wdata[5:0];
				end
				sra_pkg::A_SHUT:
				begin
					if (wdata[7:0] > 8'(sra_pkg::RELAY_MAX))
						rej = sra_pkg::ER_RANGE;
					else
					begin
						next_shutSel = wdata[5:0];
						next_shutNc = wdata[sra_pkg::SHUT_POL_BIT];
					end
				end
				sra_pkg::A_ZCTL:
				begin
					if (!wdata[0] && zUnqualified)
						rej = sra_pkg::ER_NOAUTO;
					else
						next_zSel = wdata[0];
				end
				sra_pkg::A_REC:
				begin
					if (wdata[7:0] > 8'(sra_pkg::DAC_MAX))
						rej = sra_pkg::ER_RANGE;
					else if (wdata[11:8] == sra_pkg::FUNC_BAD || wdata[11:8] > sra_pkg::FUNC_MAX)
						rej = sra_pkg::ER_FUNC;
					else
					begin
						for (int i = 0; i < NSRC; i++)
							if (wdata[3:0] != 4'h0 && srcDac[i] == wdata[3:0])
								rej = sra_pkg::ER_SETSRC;
						if (rej == sra_pkg::ER_NONE)
						begin
							next_recDac = wdata[3:0];
							next_recFunc = wdata[11:8];
						end
					end
				end
				sra_pkg::A_STAT:
				begin
					if (wdata[sra_pkg::STAT_REJ_BIT])
						next_rejSticky = 1'b0;
					if (wdata[sra_pkg::STAT_NSD_BIT])
						next_noSrcSticky = 1'b0;
				end
				default:
				begin
					for (int i = 0; i < NSRC; i++)
					begin
						if (addr == sra_pkg::A_SRC + 8'(4 * i))
						begin
							if (wdata[7:0] > 8'(sra_pkg::DAC_MAX))
								rej = sra_pkg::ER_RANGE;
							else if (wdata[3:0] != 4'h0 && wdata[3:0] == recDac)
								rej = sra_pkg::ER_SETREC;
							else
							begin
								for (int j = 0; j < NSRC; j++)
									if (j != i && wdata[3:0] != 4'h0 && srcDac[j] == wdata[3:0])
										rej = sra_pkg::ER_SETSRC;
								if (rej == sra_pkg::ER_NONE)
									next_srcDac[i] = wdata[3:0];
							end
						end
					end
				end
			endcase
		end
		// A new event is raised after the clear so that it is never lost.
		if (rej != sra_pkg::ER_NONE)
		begin
			next_errCode = rej;
			next_rejSticky = 1'b1;
		end
		if (noSrc)
			next_noSrcSticky = 1'b1;
	end

	assign noSrc = layerStart && srcDac[layerSrc] == 4'h0;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			headType <= sra_pkg::RST_HEAD;
			idxSel <= '0;
			shutSel <= '0;
			shutNc <= 1'b0;
			zSel <= sra_pkg::RST_ZSEL;
			srcDac <= '0;
			recDac <= '0;
			recFunc <= '0;
			errCode <= sra_pkg::ER_NONE;
			rejSticky <= 1'b0;
			noSrcSticky <= 1'b0;
		end
		else
		begin
			headType <= next_headType;
			idxSel <= next_idxSel;
			shutSel <= next_shutSel;
			shutNc <= next_shutNc;
			zSel <= next_zSel;
			srcDac <= next_srcDac;
			recDac <= next_recDac;
			recFunc <= next_recFunc;
			errCode <= next_errCode;
			rejSticky <= next_rejSticky;
			noSrcSticky <= next_noSrcSticky;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Index relay pulse sequencer and Z value tracking.

	sra_seq_t    seq;
	sra_seq_t    next_seq;
	logic [31:0] phaseCnt;
	logic [31:0] next_phaseCnt;
	logic        dualClosed;
	logic        next_dualClosed;
	logic [2:0]  position;
	logic [2:0]  next_position;
	logic [31:0] secCnt;
	logic [31:0] next_secCnt;
	logic [15:0] sensorZ;
	logic [15:0] next_sensorZ;
	logic        zFrozen;
	logic        next_zFrozen;
	logic        phaseEnd;

	assign busy = seq != SQ_IDLE;
	assign phaseEnd = phaseCnt == 32'(SEC_CYCLES - 1);

	always_comb
	begin
		next_seq = seq;
		next_phaseCnt = phaseCnt;
		next_dualClosed = dualClosed;
		next_position = position;
		if (busy)
			next_phaseCnt = phaseEnd ? 32'h0000_0000 : phaseCnt + 32'h0000_0001;
		// Position advances count whole crystal steps; the rotary head wraps at six.
		case (seq)
			SQ_IDLE:
			begin
				// Requests arriving while a sequence runs are dropped, not queued.
				if (switchReq && idxSel != 6'h00)
				begin
					if (headType == sra_pkg::HT_DUAL)
						next_dualClosed = !dualClosed;
					else if (headType == sra_pkg::HT_SIX || headType == sra_pkg::HT_ROTARY)
						next_seq = SQ_ON1;
				end
			end
			SQ_ON1:
			begin
				if (phaseEnd)
				begin
					if (headType == sra_pkg::HT_SIX)
						next_seq = SQ_OFF1;
					else
					begin
						next_seq = SQ_IDLE;
						next_position = (position == sra_pkg::ROT_POS_MAX) ? 3'h0 : position + 3'h1;
					end
				end
			end
			SQ_OFF1:
				if (phaseEnd)
					next_seq = SQ_ON2;
			SQ_ON2:
			begin
				if (phaseEnd)
				begin
					next_seq = SQ_IDLE;
					next_position = (position == sra_pkg::ROT_POS_MAX) ? 3'h0 : position + 3'h1;
				end
			end
			default:
				next_seq = SQ_IDLE;
		endcase
		if (headAccepted)
		begin
			next_dualClosed = 1'b0;
			next_position = 3'h0;
		end
	end

	always_comb
	begin
		next_secCnt = (secCnt == 32'(SEC_CYCLES - 1)) ? 32'h0000_0000 : secCnt + 32'h0000_0001;
		next_sensorZ = sensorZ;
		next_zFrozen = zFrozen;
		if (crystalReplaced)
			next_zFrozen = 1'b0;
		if (zCalcFail)
			next_zFrozen = 1'b1;
		if (secCnt == 32'(SEC_CYCLES - 1) && !zSel && !zFrozen && !zCalcFail)
			next_sensorZ = zCalcValue;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			seq <= SQ_IDLE;
			phaseCnt <= '0;
			dualClosed <= 1'b0;
			position <= '0;
			secCnt <= '0;
			sensorZ <= '0;
			zFrozen <= 1'b0;
		end
		else
		begin
			seq <= next_seq;
			phaseCnt <= next_phaseCnt;
			dualClosed <= next_dualClosed;
			position <= next_position;
			secCnt <= next_secCnt;
			sensorZ <= next_sensorZ;
			zFrozen <= next_zFrozen;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Relay, recorder and read data outputs.

	logic        stopLatch;
	logic        next_stopLatch;
	logic        shutCond;
	logic        shutContact;
	logic        idxClosed;
	logic [37:0] next_relayOut;
	logic        next_recActive;
	logic [1:0]  next_recOwner;
	logic        next_recConflict;
	logic        next_stopReq;
	logic [31:0] next_rdata;
	logic        ownOn;
	logic [2:0]  contenders;

	always_comb
	begin
		next_stopLatch = stopLatch;
		if (layerStart)
			next_stopLatch = 1'b0;
		if (stopCmd || noSrc)
			next_stopLatch = 1'b1;
	end

	// Leaving the coating state drops the condition on its own.
	assign shutCond = !stopLatch && !stopCmd && !rateHold
		&& (layerState == sra_pkg::LS_CTRL_DELAY || layerState == sra_pkg::LS_SHUT_DELAY
		|| layerState == sra_pkg::LS_COATING_STATE || layerState == sra_pkg::LS_MANUAL
		|| rateSample);
	assign shutContact = shutNc ? !shutCond : shutCond;
	assign idxClosed = headType != sra_pkg::HT_SINGLE
		&& (seq == SQ_ON1 || seq == SQ_ON2 || (headType == sra_pkg::HT_DUAL && dualClosed));
	assign ownOn = materialActive && recWanted && recDac != 4'h0;
	assign contenders = 3'(priAggOn) + 3'(secAggOn) + 3'(ownOn) + 3'(otherSnsOn);

	generate
		for (genvar i = 0; i < sra_pkg::NUM_RELAYS; i++)
		begin : g_relay
			assign next_relayOut[i] = (f_hit(idxSel, i) && idxClosed)
				|| (f_hit(shutSel, i) && shutContact);
		end
	endgenerate

	always_comb
	begin
		// Lower code wins; own sensor wins a tie between two sensors of one layer.
		next_recActive = 1'b0;
		next_recOwner = 2'h0;
		if (priAggOn)
			next_recOwner = 2'h0;
		else if (secAggOn)
			next_recOwner = 2'h1;
		else if (ownOn && snsPrimary)
		begin
			next_recOwner = 2'h2;
			next_recActive = 1'b1;
		end
		else if (otherSnsOn && otherSnsPrimary)
			next_recOwner = 2'h2;
		else if (ownOn)
		begin
			next_recOwner = 2'h3;
			next_recActive = 1'b1;
		end
		else
			next_recOwner = 2'h3;
		next_recConflict = contenders > 3'h1 && !stopLatch && !stopCmd;
		next_stopReq = noSrc;
		next_rdata = 32'h0000_0000;
		if (rdEn)
		begin
			case (addr)
				sra_pkg::A_HEAD: next_rdata = {29'h0, headType};
				sra_pkg::A_IDX:  next_rdata = {26'h0, idxSel};
				sra_pkg::A_SHUT: next_rdata = {23'h0, shutNc, 2'h0, shutSel};
				sra_pkg::A_ZCTL: next_rdata = {31'h0, zSel};
				sra_pkg::A_SNZ:  next_rdata = {16'h0, sensorZ};
				sra_pkg::A_REC:  next_rdata = {20'h0, recFunc, 4'h0, recDac};
				sra_pkg::A_STAT: next_rdata = {21'h0, position, 1'b0, zFrozen, recConflict,
					dualClosed, busy, 1'b0, noSrcSticky, rejSticky};
				sra_pkg::A_ERR:  next_rdata = {29'h0, errCode};
				default:
				begin
					for (int i = 0; i < NSRC; i++)
						if (addr == sra_pkg::A_SRC + 8'(4 * i))
							next_rdata = {28'h0, srcDac[i]};
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			stopLatch <= 1'b0;
			relayOut <= '0;
			recActive <= 1'b0;
			recOwner <= '0;
			recConflict <= 1'b0;
			stopReq <= 1'b0;
			rdata <= '0;
		end
		else
		begin
			stopLatch <= next_stopLatch;
			relayOut <= next_relayOut;
			recActive <= next_recActive;
			recOwner <= next_recOwner;
			recConflict <= next_recConflict;
			stopReq <= next_stopReq;
			rdata <= next_rdata;
		end
	end

endmodule : sra_core

/* hw/sra_pkg.sv */
// Constants shared by the sensor relay and analog output assignment block.
// Function
// - Index relay selection 0 to 38, 0 disables.
// - Multi-position heads need a nonzero index relay.
// - Index relay contact is always normally open.
// - Dual head toggles relay on each request.
// - Six-position head: close, open, close, open, one second each; the code returns to idle after the second close.
// - Rotary head: one one-second closure per request.
// - Rotary head has six positions, no direct select.
// - Shutter relay selection 0 to 38, 0 none.
// - Shutter true in delay, coating, manual, sampling.
// - Shutter false after coating, stop or hold.
// - Shutter polarity 0 normally open, 1 closed.
// - Z source select; auto refused when unqualified.
// - Auto Z value refreshed once per second.
// - Auto Z failure freezes value until replacement.
// - Recorder output selection 0 to 6.
// - Recorder function codes 0-4, 6-9 only.
// - Output cannot be recorder and source both.
// - Output cannot serve two source channels.
// - Recorder conflict flag, non-fatal, cleared by stop.
// - Conflict priority: aggregates first, primary before secondary.
// - Layer start without source output forces stop.
// - Recorder inactive unless material is active.
// - Head types 1, 2, 6, 7; single hides index relay.
package sra_pkg;

	// Register byte offsets.
	localparam logic [7:0] A_HEAD  = 8'h00;
	localparam logic [7:0] A_IDX   = 8'h04;
	localparam logic [7:0] A_SHUT  = 8'h08;
	localparam logic [7:0] A_ZCTL  = 8'h0C;
	localparam logic [7:0] A_SNZ   = 8'h10;
	localparam logic [7:0] A_REC   = 8'h14;
	localparam logic [7:0] A_STAT  = 8'h18;
	localparam logic [7:0] A_ERR   = 8'h1C;
	localparam logic [7:0] A_SRC   = 8'h20;

	// Field positions.
	localparam int SHUT_POL_BIT = 8;
	localparam int REC_FUNC_LSB = 8;
	localparam int STAT_REJ_BIT = 0;
	localparam int STAT_NSD_BIT = 1;

	// Head type codes.
	localparam logic [2:0] HT_SINGLE = 3'h1;
	localparam logic [2:0] HT_DUAL   = 3'h2;
	localparam logic [2:0] HT_SIX    = 3'h6;
	localparam logic [2:0] HT_ROTARY = 3'h7;

	// Reset values.
	localparam logic [2:0] RST_HEAD = HT_SINGLE;
	localparam logic       RST_ZSEL = 1'b1;

	// Limits.
	localparam logic [5:0] RELAY_MAX   = 6'h26;
	localparam logic [3:0] DAC_MAX     = 4'h6;
	localparam logic [3:0] FUNC_BAD    = 4'h5;
	localparam logic [3:0] FUNC_MAX    = 4'h9;
	localparam logic [2:0] ROT_POS_MAX = 3'h5;
	localparam int         NUM_RELAYS  = 38;

	// Layer state codes presented on the layer state input.
	localparam logic [2:0] LS_IDLE          = 3'h0;
	localparam logic [2:0] LS_CTRL_DELAY    = 3'h1;
	localparam logic [2:0] LS_SHUT_DELAY    = 3'h2;
	localparam logic [2:0] LS_COATING_STATE = 3'h3;
	localparam logic [2:0] LS_MANUAL        = 3'h4;

	// Reject reason codes.
	localparam logic [2:0] ER_NONE   = 3'h0;
	localparam logic [2:0] ER_RANGE  = 3'h1;
	localparam logic [2:0] ER_IDXREQ = 3'h2;
	localparam logic [2:0] ER_SETSRC = 3'h3;
	localparam logic [2:0] ER_SETREC = 3'h4;
	localparam logic [2:0] ER_NOAUTO = 3'h5;
	localparam logic [2:0] ER_FUNC   = 3'h6;
	localparam logic [2:0] ER_BUSY   = 3'h7;

	// Timing.
	localparam longint CLK_HZ      = 250000000;
	localparam longint PHASE_S     = 1;
	localparam int     SEC_CYCLES  = int'(PHASE_S * CLK_HZ);

endpackage : sra_pkg

/* sim/sra_core_chk.sv */
// Assertion checker for the sensor relay assignment block.
`timescale 1ns/1ps
module sra_core_chk
(
	// Clock and reset.
	input wire logic       clk,
	input wire logic       nrst,
	// Watched ports.
	input wire logic       layerStart,
	input wire logic       stopCmd,
	input wire logic       materialActive,
	input wire logic       recWanted,
	input wire logic       snsPrimary,
	input wire logic       priAggOn,
	input wire logic       secAggOn,
	input wire logic [3:0] recDac,
	input wire logic [3:0] recFunc,
	input wire logic       recActive,
	input wire logic [1:0] recOwner,
	input wire logic       recConflict,
	input wire logic       stopReq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////////////
	a_stop_cause: assert property (stopReq |-> $past(layerStart) ##1 !stopReq)
		else $error("stop request without layer start or too long");
	a_rec_material: assert property (recActive |-> $past(materialActive && recWanted))
		else $error("recorder active without active material");
	a_conf_stop: assert property ($past(stopCmd) |-> !recConflict)
		else $error("conflict shown after stop");
	a_pri_wins: assert property (recConflict && $past(priAggOn) |-> recOwner == 2'h0)
		else $error("primary aggregate lost the output");
	a_sec_next: assert property (recConflict && $past(secAggOn && !priAggOn) |-> recOwner == 2'h1)
		else $error("secondary aggregate lost the output");
	a_own_class: assert property (recActive |-> !$past(priAggOn || secAggOn)
		&& recOwner == {1'b1, !$past(snsPrimary)})
		else $error("own sensor owner wrong");
	a_dac_range: assert property (recDac <= 4'h6)
		else $error("recorder output out of range");
	a_func_valid: assert property (recFunc <= 4'h9 && recFunc != 4'h5)
		else $error("recorder function invalid");
endmodule : sra_core_chk
////////////////////////////////////////////////////////////////////////////////
bind sra_core sra_core_chk u_chk (.clk(clk), .nrst(nrst), .layerStart(layerStart),
	.stopCmd(stopCmd), .materialActive(materialActive), .recWanted(recWanted),
	.snsPrimary(snsPrimary), .priAggOn(priAggOn), .secAggOn(secAggOn), .recDac(recDac),
	.recFunc(recFunc), .recActive(recActive), .recOwner(recOwner),
	.recConflict(recConflict), .stopReq(stopReq));

/* sim/sra_head_model.sv */
// Behavioural sensor head that counts index relay closures.
`timescale 1ns/1ps
module sra_head_model
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        nrst,
	// Index relay contact, high when closed.
	input  wire logic        contact,
	// Observations.
	output logic      [7:0]  pulses,
	output logic      [15:0] lenHi,
	output logic      [15:0] lenLo
);
	logic        last;
	logic [15:0] run;
	// A real head steps only on closure, so lengths are measured in whole cycles.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			{last, pulses, run, lenHi, lenLo} <= 57'h0;
		end
		else
		begin
			last <= contact;
			run <= (contact != last) ? 16'h0001 : run + 16'h0001;
			if (contact && !last)
			begin
				pulses <= pulses + 8'h01;
				lenLo <= run;
			end
			if (!contact && last)
				lenHi <= run;
		end
	end
endmodule : sra_head_model

/* sim/tb_top.sv */
// Self-checking bench for the sensor relay assignment block.
`timescale 1ns/1ps
module tb_top;
	localparam int S = 8;
	logic        clk, nrst, wrEn, rdEn, switchReq, rateSample, rateHold, stopCmd;
	logic        layerStart, layerSrc, zUnqualified, zCalcFail, crystalReplaced;
	logic        materialActive, recWanted, snsPrimary, priAggOn, secAggOn;
	logic        otherSnsOn, otherSnsPrimary, recActive, recConflict, stopReq;
	logic [1:0]  recOwner;
	logic [2:0]  layerState;
	logic [3:0]  recDac, recFunc, e;
	logic [5:0]  ix;
	logic [7:0]  addr, pulses;
	logic [15:0] zCalcValue, rnd, lenHi, lenLo;
	logic [31:0] wdata, rdata, rv;
	logic [37:0] relayOut;
	int          n_mismatch, checks, i;

	sra_core #(.NSRC(2), .SEC_CYCLES(S)) uut (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .switchReq(switchReq),
		.layerState(layerState), .rateSample(rateSample), .rateHold(rateHold),
		.stopCmd(stopCmd), .layerStart(layerStart), .layerSrc(layerSrc),
		.zUnqualified(zUnqualified), .zCalcValue(zCalcValue), .zCalcFail(zCalcFail),
		.crystalReplaced(crystalReplaced), .materialActive(materialActive),
		.recWanted(recWanted), .snsPrimary(snsPrimary), .priAggOn(priAggOn),
		.secAggOn(secAggOn), .otherSnsOn(otherSnsOn), .otherSnsPrimary(otherSnsPrimary),
		.relayOut(relayOut), .recDac(recDac), .recFunc(recFunc), .recActive(recActive),
		.recOwner(recOwner), .recConflict(recConflict), .stopReq(stopReq));
	sra_head_model hm (.clk(clk), .nrst(nrst), .contact(relayOut[4]), .pulses(pulses),
		.lenHi(lenHi), .lenLo(lenLo));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	function automatic logic shut_exp(input logic [5:0] r, input logic p);
		return ((r[3:1] >= 3'h1 && r[3:1] <= 3'h4 || r[0]) && !(r[4] & r[5])) ^ p;
	endfunction : shut_exp

	// Bits are material, wanted, primary, pri agg, sec agg, other, other primary.
	function automatic logic [3:0] rec_exp(input logic [6:0] v);
		logic       own;
		logic [1:0] ow;
		own = v[6] & v[5];
		if (v[3])
			ow = 2'h0;
		else if (v[2])
			ow = 2'h1;
		else if (own && v[4] || v[1] && v[0])
			ow = 2'h2;
		else
			ow = 2'h3;
		return {own && !v[3] && !v[2] && (v[4] || !(v[1] && v[0])), ow,
			(3'(own) + 3'(v[3]) + 3'(v[2]) + 3'(v[1])) > 3'h1};
	endfunction : rec_exp
	////////////////////////////////////////////////////////////////////////////////
	task give_verdict;
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	task chkb(input string nm, input logic x, input logic g);
		chk(nm, {31'h0, x}, {31'h0, g});
	endtask : chkb

	task wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wrEn <= 1'b1;
		@(posedge clk);
		wrEn <= 1'b0;
		@(posedge clk);
	endtask : wr

	task rd(input logic [7:0] a);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk);
		rdEn <= 1'b0;
		#1;
		rv = rdata;
		@(posedge clk);
	endtask : rd

	task sw;
		switchReq <= 1'b1;
		@(posedge clk);
		switchReq <= 1'b0;
		@(posedge clk);
	endtask : sw

	// Polls status until the head has seen n closures and the sequence is idle.
	task waitp(input logic [7:0] n);
		int k;
		k = 0;
		rd(sra_pkg::A_STAT);
		while ((pulses !== n || rv[3] !== 1'b0) && k < 100)
		begin
			rd(sra_pkg::A_STAT);
			k++;
		end
		if (k == 100)
		begin
			n_mismatch++;
			give_verdict();
		end
		// The head model logs a closure length one edge after the contact opens.
		repeat (2) @(posedge clk);
	endtask : waitp

	task start(input logic s, input logic x);
		layerSrc <= s;
		layerStart <= 1'b1;
		@(posedge clk);
		layerStart <= 1'b0;
		#1;
		chkb("stopReq", x, stopReq);
		@(posedge clk);
	endtask : start
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{nrst, wrEn, rdEn, switchReq, rateSample, rateHold, stopCmd, layerStart} = 8'h00;
		{layerSrc, zUnqualified, zCalcFail, crystalReplaced, materialActive} = 5'h00;
		{recWanted, snsPrimary, priAggOn, secAggOn, otherSnsOn, otherSnsPrimary} = 6'h00;
		{addr, wdata, layerState, zCalcValue, ix} = 65'h0;
		rnd = 16'h0b28;
		n_mismatch = 0;
		checks = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chkb("relayIdle", 1'b1, relayOut == 38'h00_0000_0000);
		rd(sra_pkg::A_HEAD);
		chk("headReset", 32'h0000_0001, rv);
		rd(sra_pkg::A_ZCTL);
		chk("zSelReset", 32'h0000_0001, rv);
		rd(sra_pkg::A_SHUT);
		chk("shutReset", 32'h0000_0000, rv);
		for (i = 0; i < 3; i++)
		begin
			wr(sra_pkg::A_HEAD, 32'(i == 0 ? 2 : i + 5));
			rd(sra_pkg::A_HEAD);
			chk("headNoIdx", 32'h0000_0001, rv);
		end
		rd(sra_pkg::A_ERR);
		chk("errIdxReq", 32'h0000_0002, rv);
		wr(sra_pkg::A_IDX, 32'h0000_0027);
		rd(sra_pkg::A_ERR);
		chk("errRange", 32'h0000_0001, rv);
		for (i = 0; i < 12; i++)
		begin
			rnd = lfsr(rnd);
			wr(sra_pkg::A_IDX, 32'(rnd[5:0]));
			if (rnd[5:0] <= 6'h26)
				ix = rnd[5:0];
			rd(sra_pkg::A_IDX);
			chk("idxSel", 32'(ix), rv);
		end
		wr(sra_pkg::A_IDX, 32'h0000_0005);
		sw();
		#1;
		chkb("singleIdle", 1'b0, relayOut[4]);
		@(posedge clk);
		wr(sra_pkg::A_HEAD, 32'h0000_0002);
		sw();
		#1;
		chkb("dualClose", 1'b1, relayOut[4]);
		@(posedge clk);
		sw();
		#1;
		chkb("dualOpen", 1'b0, relayOut[4]);
		@(posedge clk);
		wr(sra_pkg::A_HEAD, 32'h0000_0007);
		sw();
		sw();
		waitp(8'h02);
		chk("rotHigh", 32'(S), 32'(lenHi));
		chk("rotPos", 32'h0000_0001, 32'(rv[10:8]));
		for (i = 0; i < 5; i++)
		begin
			sw();
			waitp(8'(3 + i));
		end
		chk("rotWrap", 32'h0000_0000, 32'(rv[10:8]));
		wr(sra_pkg::A_HEAD, 32'h0000_0006);
		sw();
		waitp(8'h09);
		chk("sixHigh", 32'(S), 32'(lenHi));
		chk("sixLow", 32'(S), 32'(lenLo));
		zCalcValue <= 16'h1234;
		zUnqualified <= 1'b1;
		wr(sra_pkg::A_ZCTL, 32'h0000_0000);
		rd(sra_pkg::A_ERR);
		chk("errAutoZ", 32'h0000_0005, rv);
		zUnqualified <= 1'b0;
		wr(sra_pkg::A_ZCTL, 32'h0000_0000);
		repeat (2 * S + 2) @(posedge clk);
		rd(sra_pkg::A_SNZ);
		chk("zLoad", 32'h0000_1234, rv);
		zCalcFail <= 1'b1;
		@(posedge clk);
		zCalcFail <= 1'b0;
		zCalcValue <= 16'h5678;
		repeat (3 * S) @(posedge clk);
		rd(sra_pkg::A_SNZ);
		chk("zFrozen", 32'h0000_1234, rv);
		crystalReplaced <= 1'b1;
		@(posedge clk);
		crystalReplaced <= 1'b0;
		repeat (3 * S) @(posedge clk);
		rd(sra_pkg::A_SNZ);
		chk("zThawed", 32'h0000_5678, rv);
		wr(sra_pkg::A_SRC, 32'h0000_0002);
		for (i = 0; i < 10; i++)
		begin
			wr(sra_pkg::A_REC, 32'({4'(i), 8'h03}));
			rd(sra_pkg::A_REC);
			chk("recFunc", 32'(i == 5 ? 4 : i), 32'(recFunc));
		end
		chk("recDac", 32'h0000_0003, 32'(recDac));
		wr(sra_pkg::A_REC, 32'h0000_0907);
		rd(sra_pkg::A_ERR);
		chk("errDac", 32'h0000_0001, rv);
		wr(sra_pkg::A_REC, 32'h0000_0902);
		rd(sra_pkg::A_ERR);
		chk("errIsSrc", 32'h0000_0003, rv);
		wr(sra_pkg::A_SRC + 8'h04, 32'h0000_0003);
		rd(sra_pkg::A_ERR);
		chk("errIsRec", 32'h0000_0004, rv);
		wr(sra_pkg::A_SRC + 8'h04, 32'h0000_0002);
		rd(sra_pkg::A_ERR);
		chk("errTwoSrc", 32'h0000_0003, rv);
		start(1'b0, 1'b0);
		for (i = 0; i < 40; i++)
		begin
			rnd = lfsr(rnd);
			{materialActive, recWanted, snsPrimary, priAggOn, secAggOn, otherSnsOn,
				otherSnsPrimary} <= rnd[6:0];
			e = rec_exp(rnd[6:0]);
			@(posedge clk);
			#1;
			chkb("recActive", e[3], recActive);
			chk("recOwner", 32'(e[2:1]), 32'(recOwner));
			chkb("recConflict", e[0], recConflict);
			@(posedge clk);
		end
		for (i = 0; i < 32; i++)
		begin
			if (i % 16 == 0)
				wr(sra_pkg::A_SHUT, 32'({i[4], 8'h0a}));
			rnd = lfsr(rnd);
			{layerState, rateSample, rateHold} <= {rnd[3:0], rnd[4] & rnd[5]};
			@(posedge clk);
			#1;
			chkb("shutter", shut_exp(rnd[5:0], i[4]), relayOut[9]);
			@(posedge clk);
		end
		wr(sra_pkg::A_SHUT, 32'h0000_000a);
		{layerState, rateSample, rateHold} <= 5'h0c;
		{materialActive, recWanted, snsPrimary, priAggOn, secAggOn, otherSnsOn,
			otherSnsPrimary} <= 7'h0c;
		stopCmd <= 1'b1;
		@(posedge clk);
		stopCmd <= 1'b0;
		#1;
		chkb("confStop", 1'b0, recConflict);
		@(posedge clk);
		#1;
		chkb("shutStop", 1'b0, relayOut[9]);
		chkb("confHeld", 1'b0, recConflict);
		@(posedge clk);
		start(1'b1, 1'b1);
		rd(sra_pkg::A_STAT);
		chkb("noSrcFlag", 1'b1, rv[1]);
		start(1'b0, 1'b0);
		#1;
		chkb("shutResume", 1'b1, relayOut[9]);
		chkb("confBack", 1'b1, recConflict);
		give_verdict();
	end
endmodule : tb_top
